// file: hdl/ubd_defines.svh
`ifndef UBD_DEFINES_SVH
`define UBD_DEFINES_SVH
// Descriptor table base in USB RAM and bytes per descriptor
`define UBD_BDT_BASE      16'h2000
`define UBD_BD_BYTES      3'h4
// Status byte fields
`define UBD_ST_OWN        7
`define UBD_ST_DTS        6
`define UBD_ST_TOGGLE_CHECK_EN      3
`define UBD_ST_BUFFER_STALL_EN     2
`define UBD_ST_PID_LO     2
`define UBD_ST_BC9        1
`define UBD_ST_BC8        0
// Buffering modes
`define UBD_MODE_NONE     2'h0
`define UBD_MODE_EP0OUT   2'h1
`define UBD_MODE_ALL      2'h2
`define UBD_MODE_NOT_EP0  2'h3
// Register map (word index on the plain register port)
`define UBD_REG_CFG       4'h0
`define UBD_REG_CTRL      4'h1
`define UBD_REG_XSTAT     4'h2
`define UBD_REG_BDSEL     4'h3
`define UBD_REG_BDSTAT    4'h4
`define UBD_REG_BDCNT     4'h5
`define UBD_REG_BDADRL    4'h6
`define UBD_REG_BDADRH    4'h7
// Config / control / transfer status bits
`define UBD_CFG_EN        2
`define UBD_CTRL_PPRST    0
`define UBD_XS_ODD        1
`define UBD_XS_DIR        2
`define UBD_XS_EP_LO      3
`define UBD_XS_DONE       7
// Handshakes
`define UBD_HS_ACK        2'h1
`define UBD_HS_NAK        2'h2
`define UBD_HS_STALL      2'h3
`define UBD_HS_NONE       2'h0
// Token identifiers
`define UBD_PID_SETUP     4'hd
`endif

// file: hdl/ubd_engine.sv
// Chosen here: strobed register access and the address map.
`timescale 1ns/1ps
`include "ubd_defines.svh"
// How it works
// - IN sends count bytes, writes sent count
// - OUT count is limit, received count written
// - Oversize OUT: NAK, count untouched
// - Count is ten bits, top in status
// - Buffer address unchecked, passed straight through
// - Two-bit mode selects four buffering schemes
// - Per-endpoint pointer, Even on module enable
// - Pointer flips on each completed transaction
// - Last parity recorded in transfer status
// - Pointer reset control forces all Even
// - No ping-pong: OUT 2n, IN 2n+1
// - EP0 OUT ping-pong layout, seventeen descriptors
// - Full ping-pong: four per endpoint
// - Ping-pong except EP0, thirty descriptors
// - Table at 2000h, four bytes each
// - Released status holds token PID, except on a SETUP stall release
// - Expected toggle ignored unless checking on
// - Descriptor storage has no reset value
// - Ownership cleared when transaction finishes
// - Toggle mismatch: ACK, not stored, kept
// - Stall answers STALL; SETUP releases it
// - Count overflow carries into status bits
module ubd_engine
	import ubd_pkg::*;
#(
	parameter int NUM_BD = 32,
	parameter int NUM_EP = 8
) (
	input  wire logic        clock,
	input  wire logic        resetn,
	// Register port
	input  wire logic [3:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	// Token summary from the serial engine
	input  wire logic        tok_valid,
	input  wire logic [2:0]  tok_ep,
	input  wire logic        tok_in,
	input  wire logic [3:0]  tok_pid,
	input  wire logic        tok_data1,
	input  wire logic [9:0]  tok_len,
	input  wire logic        tok_err,
	// Handshake and buffer side
	output logic             busy,
	output logic             hs_valid,
	output logic      [1:0]  hs_code,
	output logic             xfer_valid,
	output logic      [15:0] xfer_ram_addr,
	output logic      [9:0]  xfer_len,
	output logic             xfer_store,
	output logic      [15:0] bd_ram_addr
);
	// ----------------------------------------------------------------
	// Descriptor storage: plain RAM, never reset
	// ----------------------------------------------------------------
	// Firmware and engine share these bytes without any lock
	logic [7:0] bd_stat [NUM_BD];
	logic [7:0] bd_cnt  [NUM_BD];
	logic [7:0] bd_adrl [NUM_BD];
	logic [7:0] bd_adrh [NUM_BD];

	// ----------------------------------------------------------------
	// Block state: one packed struct, registered as a whole
	// ----------------------------------------------------------------
	typedef struct packed {
		// Sequencer and software-visible registers
		ubd_state_t        state;
		logic [7:0]        cfg;
		logic [7:0]        xstat;
		logic [4:0]        bdsel;
		// Ping-pong pointers, one bit per endpoint and direction
		logic [NUM_EP-1:0] ptr_out;
		logic [NUM_EP-1:0] ptr_in;
		// Token captured on acceptance (idx and pp one cycle later, in FETCH), held for the whole walk
		logic [4:0]        idx;
		logic [2:0]        ep;
		logic              dir_in;
		logic              odd;
		logic              pp;
		logic [3:0]        pid;
		logic              data1;
		logic [9:0]        len;
		logic              err;
		// Registered outputs
		logic [7:0]        rdata;
		logic              busy;
		logic              hs_valid;
		logic [1:0]        hs_code;
		logic              xv;
		logic [15:0]       xaddr;
		logic [9:0]        xlen;
		logic              xstore;
		// Write-back staging for the descriptor RAM
		logic              wb_en;
		logic [7:0]        wb_stat;
		logic              wb_cnt;
		logic [9:0]        wb_len;
		logic              flip;
		logic [15:0]       bdaddr;
	} ubd_state_s_t;

	// Present state and the value the next edge loads
	ubd_state_s_t s_reg;
	ubd_state_s_t s_next;

	// ----------------------------------------------------------------
	// Descriptor index lookup, driven from the captured token
	// ----------------------------------------------------------------
	ubd_map_if mif ();
	ubd_map u_map (
		.m (mif)
	);
	// Mode from config, token fields from the captured copy
	assign mif.mode   = s_reg.cfg[1:0];
	assign mif.ep     = s_reg.ep;
	assign mif.dir_in = s_reg.dir_in;
	assign mif.odd    = s_reg.odd;

	// ----------------------------------------------------------------
	// Register read decode
	// ----------------------------------------------------------------
	function automatic logic [7:0] rd_mux(input logic [3:0] a, input ubd_state_s_t s,
		input logic [7:0] st, input logic [7:0] cn, input logic [7:0] al,
		input logic [7:0] ah);
		case (a)
			`UBD_REG_CFG:    rd_mux = s.cfg;
			`UBD_REG_CTRL:   rd_mux = 8'h00;
			`UBD_REG_XSTAT:  rd_mux = s.xstat;
			`UBD_REG_BDSEL:  rd_mux = {3'h0, s.bdsel};
			`UBD_REG_BDSTAT: rd_mux = st;
			`UBD_REG_BDCNT:  rd_mux = cn;
			`UBD_REG_BDADRL: rd_mux = al;
			`UBD_REG_BDADRH: rd_mux = ah;
			default:         rd_mux = 8'h00;
		endcase
	endfunction : rd_mux

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	// Combinational helpers; st, limit and tog_ok assigned at the top of the process, en_now after the writes
	logic [7:0] st;
	logic [9:0] limit;
	logic       en_now;
	logic       tog_ok;
	always_comb begin
		s_next          = s_reg;
		st              = bd_stat[s_reg.idx];
		limit           = {st[`UBD_ST_BC9:`UBD_ST_BC8], bd_cnt[s_reg.idx]};
		tog_ok          = ~st[`UBD_ST_TOGGLE_CHECK_EN] |
			(st[`UBD_ST_DTS] == s_reg.data1);
		s_next.hs_valid = 1'b0;
		s_next.xv       = 1'b0;
		s_next.wb_en    = 1'b0;
		s_next.wb_cnt   = 1'b0;
		s_next.flip     = 1'b0;
		s_next.rdata    = 8'h00;

		// ------------------------------------------------------------
		// Register port: read data the cycle after the strobe
		// ------------------------------------------------------------
		if (reg_rd) begin
			s_next.rdata = rd_mux(reg_addr, s_reg, bd_stat[s_reg.bdsel],
				bd_cnt[s_reg.bdsel], bd_adrl[s_reg.bdsel], bd_adrh[s_reg.bdsel]);
			if (reg_addr == `UBD_REG_XSTAT) begin
				s_next.xstat[`UBD_XS_DONE] = 1'b0;                   // Read clears done
			end
		end
		// Register writes; descriptor bytes go to the RAM process below
		if (reg_wr) begin
			case (reg_addr)
				`UBD_REG_CFG:   s_next.cfg   = reg_wdata;
				`UBD_REG_BDSEL: s_next.bdsel = reg_wdata[4:0];
				default:        s_next.bdsel = s_reg.bdsel;
			endcase
		end
		// Enable rising edge or pointer reset: all pointers to Even
		// Limitation: a flip completing in the same cycle still lands
		en_now = s_next.cfg[`UBD_CFG_EN] & ~s_reg.cfg[`UBD_CFG_EN];
		if (en_now || (reg_wr && reg_addr == `UBD_REG_CTRL &&
			reg_wdata[`UBD_CTRL_PPRST])) begin
			s_next.ptr_out = '0;
			s_next.ptr_in  = '0;
		end

		// ------------------------------------------------------------
		// Token sequencer
		// ------------------------------------------------------------
		case (s_reg.state)
			UBD_IDLE: begin
				// Tokens are ignored while busy or disabled
				s_next.busy = 1'b0;
				if (tok_valid && s_reg.cfg[`UBD_CFG_EN]) begin
					s_next.state  = UBD_FETCH;
					s_next.busy   = 1'b1;
					s_next.ep     = tok_ep;
					s_next.dir_in = tok_in;
					s_next.odd    = tok_in ? s_next.ptr_in[tok_ep] : s_next.ptr_out[tok_ep];
					s_next.pid    = tok_pid;
					s_next.data1  = tok_data1;
					s_next.len    = tok_len;
					s_next.err    = tok_err;
				end
			end
			UBD_FETCH: begin
				// Index settles a cycle after capture; RAM read follows
				s_next.idx    = mif.index;
				s_next.pp     = mif.pp_used;
				s_next.bdaddr = `UBD_BDT_BASE +
					16'({mif.index, 2'b00});
				s_next.state  = UBD_RUN;
			end
			UBD_RUN: begin
				// Refusals first: ownership, error, stall, length, toggle
				s_next.state = UBD_DONE;
				if (!st[`UBD_ST_OWN]) begin
					s_next.hs_valid = 1'b1;
					s_next.hs_code  = `UBD_HS_NAK;
				end else if (s_reg.err) begin
					// Corrupt packet: silent, descriptor untouched
					s_next.hs_code  = `UBD_HS_NONE;
				end else if (st[`UBD_ST_BUFFER_STALL_EN] && s_reg.pid != `UBD_PID_SETUP) begin
					// Stall answers every token but SETUP
					s_next.hs_valid = 1'b1;
					s_next.hs_code  = `UBD_HS_STALL;
				end else if (st[`UBD_ST_BUFFER_STALL_EN]) begin
					// SETUP lifts the stall and hands the descriptor back
					s_next.state    = UBD_WBACK;
					s_next.wb_en    = 1'b1;
					s_next.wb_stat  = st;
					s_next.wb_stat[`UBD_ST_OWN]    = 1'b0;
					s_next.wb_stat[`UBD_ST_BUFFER_STALL_EN] = 1'b0;
				end else if (s_reg.dir_in) begin
					// IN sends the armed count; the host gives the handshake
					s_next.xv       = 1'b1;
					s_next.xaddr    = {bd_adrh[s_reg.idx], bd_adrl[s_reg.idx]};
					s_next.xlen     = limit;
					s_next.xstore   = 1'b0;
					s_next.state    = UBD_WBACK;
					s_next.wb_len   = limit;
				end else if (s_reg.len > limit) begin
					// Oversize OUT refused; the count keeps its armed value
					s_next.hs_valid = 1'b1;
					s_next.hs_code  = `UBD_HS_NAK;
				end else if (!tog_ok) begin
					// Wrong parity: host sees ACK, data dropped, no flip
					s_next.hs_valid = 1'b1;
					s_next.hs_code  = `UBD_HS_ACK;
				end else begin
					// Good OUT: store, acknowledge, then write back
					s_next.xv       = 1'b1;
					s_next.xaddr    = {bd_adrh[s_reg.idx], bd_adrl[s_reg.idx]};
					s_next.xlen     = s_reg.len;
					s_next.xstore   = 1'b1;
					s_next.hs_valid = 1'b1;
					s_next.hs_code  = `UBD_HS_ACK;
					s_next.state    = UBD_WBACK;
					s_next.wb_len   = s_reg.len;
				end
			end
			UBD_WBACK: begin
				// Status byte and count written on the same edge, leaving DONE; a staged SETUP
				// release keeps its own status image and leaves the count
				s_next.wb_en = 1'b1;
				if (!s_reg.wb_en) begin
					s_next.wb_cnt  = 1'b1;
					s_next.wb_stat = {1'b0, st[`UBD_ST_DTS], s_reg.pid,
						s_reg.wb_len[9:8]};
				end
				s_next.flip  = 1'b1;
				s_next.state = UBD_DONE;
			end
			UBD_DONE: begin
				// Only released descriptors flip the pointer and post status;
				// the set beats a read-clear landing in the same cycle
				if (s_reg.flip) begin
					s_next.xstat                     = 8'h00;
					s_next.xstat[`UBD_XS_DONE]       = 1'b1;
					s_next.xstat[`UBD_XS_EP_LO +: 3] = s_reg.ep;
					s_next.xstat[`UBD_XS_DIR]        = s_reg.dir_in;
					s_next.xstat[`UBD_XS_ODD]        = s_reg.odd;
					if (s_reg.dir_in)
						s_next.ptr_in[s_reg.ep]  = ~s_reg.ptr_in[s_reg.ep];
					else
						s_next.ptr_out[s_reg.ep] = ~s_reg.ptr_out[s_reg.ep];
				end
				s_next.busy  = 1'b0;
				s_next.state = UBD_IDLE;
			end
			default: begin
				// Unused code: back to idle
				s_next.state = UBD_IDLE;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			// RAM is left out: its contents stay undefined
			s_reg       <= '0;
			s_reg.state <= UBD_IDLE;
		end else begin
			s_reg <= s_next;
		end
	end

	// ----------------------------------------------------------------
	// Descriptor RAM writes: firmware, then engine write-back wins
	// ----------------------------------------------------------------
	// Firmware must not touch a descriptor the engine owns; no lock exists
	always_ff @(posedge clock) begin
		if (reg_wr && reg_addr == `UBD_REG_BDSTAT) bd_stat[s_reg.bdsel] <= reg_wdata;
		if (reg_wr && reg_addr == `UBD_REG_BDCNT)  bd_cnt[s_reg.bdsel]  <= reg_wdata;
		if (reg_wr && reg_addr == `UBD_REG_BDADRL) bd_adrl[s_reg.bdsel] <= reg_wdata;
		if (reg_wr && reg_addr == `UBD_REG_BDADRH) bd_adrh[s_reg.bdsel] <= reg_wdata;
		if (s_reg.wb_cnt) bd_cnt[s_reg.idx] <= s_reg.wb_len[7:0];
		if (s_reg.wb_en && s_reg.state == UBD_DONE)
			bd_stat[s_reg.idx] <= s_reg.wb_stat;
	end

	// ----------------------------------------------------------------
	// Outputs straight from flip-flops
	// ----------------------------------------------------------------
	assign reg_rdata     = s_reg.rdata;
	assign busy          = s_reg.busy;
	assign hs_valid      = s_reg.hs_valid;
	assign hs_code       = s_reg.hs_code;
	assign xfer_valid    = s_reg.xv;
	assign xfer_ram_addr = s_reg.xaddr;
	assign xfer_len      = s_reg.xlen;
	assign xfer_store    = s_reg.xstore;
	assign bd_ram_addr   = s_reg.bdaddr;
endmodule : ubd_engine

// file: hdl/ubd_map.sv
`timescale 1ns/1ps
`include "ubd_defines.svh"
module ubd_map
	import ubd_pkg::*;
(
	ubd_map_if.map m
);
	// ----------------------------------------------------------------
	// Fixed descriptor placement per buffering mode
	// ----------------------------------------------------------------
	logic [5:0] base;
	logic       pp;
	always_comb begin
		base = 6'h00;
		pp   = 1'b0;
		case (m.mode)
			`UBD_MODE_NONE: begin
				base = {2'b00, m.ep, 1'b0} + {5'h00, m.dir_in};
			end
			`UBD_MODE_EP0OUT: begin
				if (m.ep == 3'h0) begin
					pp   = ~m.dir_in;
					base = m.dir_in ? 6'h02 : 6'h00;
				end else begin
					base = {2'b00, m.ep, 1'b0} + 6'h01 + {5'h00, m.dir_in};
				end
			end
			`UBD_MODE_ALL: begin
				pp   = 1'b1;
				base = {1'b0, m.ep, m.dir_in, 1'b0};
			end
			`UBD_MODE_NOT_EP0: begin
				if (m.ep == 3'h0) begin
					base = {5'h00, m.dir_in};
				end else begin
					pp   = 1'b1;
					base = {1'b0, m.ep, m.dir_in, 1'b0} - 6'h02;
				end
			end
			default: begin
				base = 6'h00;
			end
		endcase
		m.pp_used = pp;
		m.index   = base[4:0] + {4'h0, pp & m.odd};
	end
endmodule : ubd_map

// file: hdl/ubd_map_if.sv
`timescale 1ns/1ps
// Endpoint/direction/parity to descriptor index lookup
interface ubd_map_if;
	logic [1:0] mode;
	logic [2:0] ep;
	logic       dir_in;
	logic       odd;
	logic [4:0] index;
	logic       pp_used;
	modport user (output mode, output ep, output dir_in, output odd,
		input index, input pp_used);
	modport map (input mode, input ep, input dir_in, input odd,
		output index, output pp_used);
endinterface : ubd_map_if

// file: hdl/ubd_pkg.sv
package ubd_pkg;
	typedef enum logic [2:0] {
		UBD_IDLE  = 3'b000,
		UBD_FETCH = 3'b001,
		UBD_RUN   = 3'b011,
		UBD_WBACK = 3'b010,
		UBD_DONE  = 3'b110
	} ubd_state_t;
endpackage : ubd_pkg

// file: test/test_usb_buffer_descriptor_table.sv
`timescale 1ns/1ps
`include "ubd_defines.svh"
// ----------------------------------------
// Descriptor engine bench
// ----------------------------------------
module test_usb_buffer_descriptor_table;
	logic        clock, resetn, reg_wr, reg_rd, tok_valid, tok_in, tok_data1, tok_err;
	logic        busy, hs_valid, xfer_valid, xfer_store, xs, xv;
	logic [3:0]  reg_addr, tok_pid;
	logic [7:0]  reg_wdata, reg_rdata, v;
	logic [2:0]  tok_ep;
	logic [1:0]  hs_code, hs;
	logic [9:0]  tok_len, xfer_len, xl, c;
	logic [15:0] xfer_ram_addr, bd_ram_addr, xa, ba;
	int          seed = 32'h75e3;
	int          miscompares = 0;
	int          num_checks = 0;
	int          m, j, e, i, k, x;
	// 40 MHz clock
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	ubd_engine #(.NUM_BD(32), .NUM_EP(8)) dut_u (.clock(clock), .resetn(resetn),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .tok_valid(tok_valid), .tok_ep(tok_ep), .tok_in(tok_in),
		.tok_pid(tok_pid), .tok_data1(tok_data1), .tok_len(tok_len), .tok_err(tok_err),
		.busy(busy), .hs_valid(hs_valid), .hs_code(hs_code), .xfer_valid(xfer_valid),
		.xfer_ram_addr(xfer_ram_addr), .xfer_len(xfer_len), .xfer_store(xfer_store),
		.bd_ram_addr(bd_ram_addr));
	ubd_host_model host_u (.clock(clock), .hs_valid(hs_valid), .hs_code(hs_code),
		.tok_valid(tok_valid), .tok_ep(tok_ep), .tok_in(tok_in), .tok_pid(tok_pid),
		.tok_data1(tok_data1), .tok_len(tok_len), .tok_err(tok_err));
	// Latch what the engine hands to the buffer side; the pulse lasts one cycle
	always @(posedge clock) begin
		if (tok_valid)
			xv <= 1'b0;
		if (xfer_valid) begin
			xv <= 1'b1;
			{xa, xl, xs, ba} <= {xfer_ram_addr, xfer_len, xfer_store, bd_ram_addr};
		end
	end
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] ex);
		num_checks++;
		if (s !== ex) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", n, ex, s);
		end
	endtask : chk
	task automatic results;
		if (miscompares == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : results
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		{reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a);
		@(posedge clock);
		{reg_addr, reg_rd} <= {a, 1'b1};
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask : rd
	// Reference descriptor index for mode, endpoint, direction and parity
	function automatic int bdx(int md, int ep, int in, int o);
		case (md)
			0: return 2 * ep + in;
			1: return (ep == 0) ? (in ? 2 : o) : 2 * ep + 1 + in;
			2: return 4 * ep + 2 * in + o;
			default: return (ep == 0) ? in : 4 * ep - 2 + 2 * in + o;
		endcase
	endfunction : bdx
	function automatic bit pp(int md, int ep, int in);
		return md == 2 || (md == 1 && ep == 0 && in == 0) || (md == 3 && ep != 0);
	endfunction : pp
	// Arm a descriptor, send one token, check handshake, transfer and write-back
	task automatic xact(input int ep, input int in, input logic [7:0] st,
		input logic [9:0] cn, input logic d, input logic [9:0] n, input logic [3:0] p,
		input int ix, input logic [1:0] eh, input logic ex);
		logic [15:0] a;
		logic [9:0]  wc;
		a = 16'($random(seed));
		wc = ex ? (in ? cn : n) : cn;
		wr(`UBD_REG_BDSEL, 8'(ix));
		wr(`UBD_REG_BDCNT, cn[7:0]);
		wr(`UBD_REG_BDADRL, a[7:0]);
		wr(`UBD_REG_BDADRH, a[15:8]);
		wr(`UBD_REG_BDSTAT, {st[7:2], cn[9:8]});
		host_u.send(3'(ep), in[0], p, d, n, hs);
		chk("busy", {15'h0, busy}, 16'h0);
		chk("handshake", {14'h0, hs}, {14'h0, eh});
		chk("xfer", {15'h0, xv}, {15'h0, ex});
		if (ex) begin
			chk("ram_addr", xa, a);
			chk("bd_addr", ba, 16'h2000 + 16'(4 * ix));
			chk("len", {6'h0, xl}, {6'h0, wc});
			chk("store", {15'h0, xs}, {15'h0, ~in[0]});
		end
		rd(`UBD_REG_BDCNT);
		chk("count", {8'h0, v}, {8'h0, wc[7:0]});
		rd(`UBD_REG_BDSTAT);
		if (ex)
			chk("status", {8'h0, v & 8'hbf}, {10'h0, p, wc[9:8]});
		else
			chk("owner", {15'h0, v[7]}, {15'h0, st[7]});
	endtask : xact
	// Main sequence: every mode, then the refusal cases
	initial begin
		{resetn, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
		repeat (10) @(posedge clock);
		resetn <= 1'b1;
		for (m = 0; m < 4; m++) begin
			wr(`UBD_REG_CFG, 8'h04 | 8'(m));
			for (j = 0; j < 2; j++) begin
				e = j * (m + 4);
				for (i = 0; i < 2; i++) begin
					wr(`UBD_REG_CTRL, 8'h01);
					for (k = 0; k < 3; k++) begin
						if (k == 2)
							wr(`UBD_REG_CTRL, 8'h01);
						x = bdx(m, e, i, (k == 1) && pp(m, e, i));
						c = 10'($random(seed));
						xact(e, i, 8'h80, c, k[0], (k == 2) ? c : c >> 1, i ? 4'h9 : 4'h1, x,
							i ? `UBD_HS_NONE : `UBD_HS_ACK, 1'b1);
						rd(`UBD_REG_XSTAT);
						if (pp(m, e, i))
							chk("odd", {15'h0, v[1]}, {15'h0, k == 1});
					end
				end
			end
		end
		wr(`UBD_REG_CFG, 8'h04);
		xact(2, 0, 8'h80, 10'h064, 0, 10'h065, 4'h1, 4, `UBD_HS_NAK, 0);
		xact(2, 0, 8'h00, 10'h064, 0, 10'h010, 4'h1, 4, `UBD_HS_NAK, 0);
		xact(2, 0, 8'h88, 10'h064, 1, 10'h010, 4'h1, 4, `UBD_HS_ACK, 0);
		xact(2, 0, 8'hc0, 10'h3ff, 0, 10'h3ff, 4'h1, 4, `UBD_HS_ACK, 1);
		xact(2, 0, 8'h84, 10'h064, 0, 10'h010, 4'h1, 4, `UBD_HS_STALL, 0);
		host_u.send(3'h2, 1'b0, `UBD_PID_SETUP, 1'b0, 10'h008, hs);
		wr(`UBD_REG_BDSEL, 8'h04);
		rd(`UBD_REG_BDSTAT);
		chk("setup_owner", {15'h0, v[7]}, 16'h0);
		results;
	end
endmodule : test_usb_buffer_descriptor_table
bind ubd_engine ubd_checker chk_u (.clock(clock), .resetn(resetn), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.tok_valid(tok_valid), .tok_len(tok_len), .tok_in(tok_in), .busy(busy),
	.hs_valid(hs_valid), .hs_code(hs_code), .xfer_valid(xfer_valid), .xfer_len(xfer_len),
	.xfer_store(xfer_store), .bd_ram_addr(bd_ram_addr));

// file: test/ubd_checker.sv
`timescale 1ns/1ps
`include "ubd_defines.svh"
// ----------------------------------------
// Engine port checker
// ----------------------------------------
module ubd_checker (
	input wire logic        clock,
	input wire logic        resetn,
	input wire logic [3:0]  reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_rdata,
	input wire logic        tok_valid,
	input wire logic [9:0]  tok_len,
	input wire logic        tok_in,
	input wire logic        busy,
	input wire logic        hs_valid,
	input wire logic [1:0]  hs_code,
	input wire logic        xfer_valid,
	input wire logic [9:0]  xfer_len,
	input wire logic        xfer_store,
	input wire logic [15:0] bd_ram_addr
);
	logic [2:0] cfg_reg;
	logic [9:0] len_reg;
	logic       in_reg;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);
	// Shadow config and the last accepted token, seen only from the pins
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			cfg_reg <= 3'h0;
			len_reg <= 10'h000;
			in_reg  <= 1'b0;
		end else begin
			if (reg_wr && reg_addr == `UBD_REG_CFG)
				cfg_reg <= reg_wdata[2:0];
			if (tok_valid && !busy) begin
				len_reg <= tok_len;
				in_reg  <= tok_in;
			end
		end
	end
	property p_fetch;
		tok_valid && !busy && cfg_reg[`UBD_CFG_EN] |=> busy [*3] ##[1:3] !busy;
	endproperty
	a_fetch: assert property (p_fetch) else $error("token not processed in time");
	property p_ack;
		xfer_valid |-> (xfer_store ? (hs_valid && hs_code == `UBD_HS_ACK) : !hs_valid);
	endproperty
	a_ack: assert property (p_ack) else $error("transfer without acknowledge");
	property p_store_len;
		xfer_valid && xfer_store |-> xfer_len == len_reg;
	endproperty
	a_store_len: assert property (p_store_len) else $error("stored length wrong");
	property p_dir;
		xfer_valid |-> xfer_store == !in_reg;
	endproperty
	a_dir: assert property (p_dir) else $error("store flag against direction");
	property p_nak;
		hs_valid && hs_code == `UBD_HS_NAK |-> !xfer_valid;
	endproperty
	a_nak: assert property (p_nak) else $error("refused packet transferred");
	property p_stall;
		hs_valid && hs_code == `UBD_HS_STALL |-> !xfer_valid;
	endproperty
	a_stall: assert property (p_stall) else $error("stalled token transferred");
	property p_table;
		xfer_valid |-> bd_ram_addr[15:7] == 9'h040 && bd_ram_addr[1:0] == 2'h0;
	endproperty
	a_table: assert property (p_table) else $error("descriptor outside table");
	property p_mode_rd;
		reg_rd && reg_addr == `UBD_REG_CFG |=> reg_rdata[1:0] == cfg_reg[1:0];
	endproperty
	a_mode_rd: assert property (p_mode_rd) else $error("mode readback wrong");
	property p_ctrl_rd;
		reg_rd && reg_addr == `UBD_REG_CTRL |=> reg_rdata == 8'h00;
	endproperty
	a_ctrl_rd: assert property (p_ctrl_rd) else $error("control reads nonzero");
	c_nak: cover property (hs_valid && hs_code == `UBD_HS_NAK);
	c_stall: cover property (hs_valid && hs_code == `UBD_HS_STALL);
	c_store: cover property (xfer_valid && xfer_store);
endmodule : ubd_checker

// file: test/ubd_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Host token source
// ----------------------------------------
module ubd_host_model (
	input  wire logic       clock,
	input  wire logic       hs_valid,
	input  wire logic [1:0] hs_code,
	output logic            tok_valid,
	output logic      [2:0] tok_ep,
	output logic            tok_in,
	output logic      [3:0] tok_pid,
	output logic            tok_data1,
	output logic      [9:0] tok_len,
	output logic            tok_err
);
	int seed = 32'h75e3;
	// Quiet bus at time zero
	initial {tok_valid, tok_ep, tok_in, tok_pid, tok_data1, tok_len, tok_err} = '0;
	// One token, then a window over the whole walk; idle fields carry noise
	task automatic send(input logic [2:0] e, input logic i, input logic [3:0] p,
		input logic d, input logic [9:0] n, output logic [1:0] hs);
		hs = 2'h0;
		@(posedge clock);
		tok_valid <= 1'b1;
		{tok_ep, tok_in, tok_pid, tok_data1, tok_len, tok_err} <= {e, i, p, d, n, 1'b0};
		@(posedge clock);
		tok_valid <= 1'b0;
		{tok_ep, tok_in, tok_pid, tok_data1, tok_len, tok_err} <= 20'($random(seed));
		repeat (7) begin
			@(posedge clock);
			#1;
			if (hs_valid)
				hs = hs_code;
		end
		// Slow host: random idle gap, spacing stays above six cycles
		repeat ($unsigned($random(seed)) % 3) @(posedge clock);
	endtask : send
endmodule : ubd_host_model
